/* logic/asbc_top.sv */
// Sequencer, input selection and result-buffer control of the converter
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module asbc_top #(
    parameter int RESULT_W = 10
) (
    input  wire logic                clk,
    input  wire logic                rst,
    // Register port
    input  wire logic [4:0]          reg_addr,
    input  wire logic [15:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [15:0]              reg_rdata,
    // Converter core
    input  wire logic                conv_trigger,
    input  wire logic                conv_done,
    input  wire logic [RESULT_W-1:0] conv_result,
    output logic                     conv_start,
    output logic [1:0]               conv_channel,
    output logic                     sample_hold_sample,
    output logic [3:0]               channel_enable,
    // Analog multiplexer selections
    output logic [3:0]               sh0_pos_input,
    output logic                     sh0_neg_input,
    output logic                     sh_upper_pos_input,
    output logic [1:0]               sh_upper_neg_input,
    // Conversion interrupt
    output logic                     conv_irq
);
    import asbc_pkg::*;

    // Parameter check
    if (RESULT_W < 1 || RESULT_W > 16) begin : g_bad_width
        $error("RESULT_W must be 1 to 16");
    end

    asbc_buf_if #(.RESULT_W(RESULT_W)) buf_bus ();  // Store link

    logic [15:0]   ctrl;            // Control register
    logic [15:0]   sel;             // Selection register
    logic [15:0]   scan_input_mask; // Scan mask register
    asbc_state_t   state;           // Sequencer state
    logic [3:0]    event_cnt;       // Sample events this period
    logic [3:0]    wr_ptr;          // Fill position
    logic          buffer_half_status; // Half being filled
    logic [3:0]    scan_pos;        // Next input to scan
    logic          scan_fresh;      // Period start, use lowest
    logic          alt_phase;       // Use B selections
    logic [3:0]    last_ch;         // Highest enabled channel

    // Control fields
    logic          auto_sample_enable;
    logic          split_buffer_mode;
    logic          alternate_input_select;
    logic          scan_enable;
    logic [1:0]    channel_count_select;
    logic [3:0]    samples_per_interrupt;
    assign auto_sample_enable     = ctrl[CTRL_AUTO];
    assign split_buffer_mode      = ctrl[CTRL_SPLIT];
    assign alternate_input_select = ctrl[CTRL_ALT];
    assign scan_enable            = ctrl[CTRL_SCAN];
    assign channel_count_select   = ctrl[CTRL_CHCNT_LO +: 2];
    assign samples_per_interrupt  = ctrl[CTRL_SPI_LO +: 4];

    // Command decode
    logic wr_cmd;        // Command write this cycle
    logic start_sample;  // Software begins sampling
    logic trigger;       // Any conversion trigger
    assign wr_cmd       = reg_wr && (reg_addr == REG_CMD);
    assign start_sample = wr_cmd && reg_wdata[CMD_SAMPLE];
    assign trigger      = conv_trigger || (wr_cmd && reg_wdata[CMD_TRIGGER]);

    // Sequence milestones
    logic result_in;   // A conversion finished
    logic event_end;   // Last channel of the event done
    logic period_end;  // Event count reached
    assign result_in  = (state == ST_CONVERT) && conv_done;
    assign event_end  = result_in && (conv_channel == last_ch[1:0]);
    assign period_end = event_end && (event_cnt == samples_per_interrupt);

    // Highest channel from the count field
    always_comb begin
        case (channel_count_select)
            CHCNT_ONE: last_ch = {2'h0, LAST_CH_ONE};
            CHCNT_TWO: last_ch = {2'h0, LAST_CH_TWO};
            default:   last_ch = {2'h0, LAST_CH_FOUR};
        endcase
    end

    // Lowest input set in the mask
    function automatic logic [3:0] lowest_in(input logic [15:0] mask);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
            if (mask[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Next input set above cur, wrapping round
    function automatic logic [3:0] next_in(input logic [15:0] mask, input logic [3:0] cur);
        logic [3:0] r;
        logic [3:0] p;
        r = cur;
        for (int i = NUM_INPUTS - 1; i >= 1; i--) begin
            p = cur + 4'(i);
            if (mask[p]) begin
                r = p;
            end
        end
        return r;
    endfunction

    // Input scanned by channel 0 on this event
    logic [3:0] scan_now;
    assign scan_now = scan_fresh ? lowest_in(scan_input_mask) : scan_pos;

    // Software registers; the buffer range takes no writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl            <= CTRL_RESET;
            sel             <= SELECT_RESET;
            scan_input_mask <= SCAN_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL:   ctrl            <= reg_wdata;
                REG_SELECT: sel             <= reg_wdata;
                REG_SCAN:   scan_input_mask <= reg_wdata;
                default:    ;  // Buffer and status ignore writes
            endcase
        end
    end

    // Sample and convert sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state        <= ST_IDLE;
            conv_start   <= 1'b0;
            conv_channel <= 2'h0;
        end else begin
            conv_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Auto mode samples on its own
                    if (auto_sample_enable || start_sample) begin
                        state <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    // All enabled channels held at once
                    if (trigger) begin
                        state        <= ST_CONVERT;
                        conv_channel <= 2'h0;
                        conv_start   <= 1'b1;
                    end
                end
                ST_CONVERT: begin
                    if (event_end) begin
                        state <= auto_sample_enable ? ST_SAMPLE : ST_IDLE;
                    end else if (result_in) begin
                        // Channels in order 0, 1, 2, 3
                        conv_channel <= conv_channel + 2'h1;
                        conv_start   <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Event counting and interrupt
    always_ff @(posedge clk) begin
        if (rst) begin
            event_cnt <= 4'h0;
            conv_irq  <= 1'b0;
        end else begin
            conv_irq <= period_end;
            if (period_end) begin
                event_cnt <= 4'h0;
            end else if (event_end) begin
                event_cnt <= event_cnt + 4'h1;
            end
        end
    end

    // Buffer fill position and half
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr             <= 4'h0;
            buffer_half_status <= 1'b0;
        end else if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_SPLIT] && !split_buffer_mode) begin
            // Entering split mode starts in the lower half
            wr_ptr             <= 4'h0;
            buffer_half_status <= 1'b0;
        end else if (period_end) begin
            // Restart fill at the start of a half or buffer
            wr_ptr <= 4'h0;
            if (split_buffer_mode) begin
                buffer_half_status <= ~buffer_half_status;
            end else begin
                buffer_half_status <= 1'b0;
            end
        end else if (result_in) begin
            wr_ptr <= wr_ptr + 4'h1;
        end
    end

    // Write address: in split mode the half bit replaces pointer bit 3
    logic [3:0] wr_addr;
    assign wr_addr = split_buffer_mode ? {buffer_half_status, wr_ptr[2:0]} : wr_ptr;

    // Scan pointer and input bank phase
    always_ff @(posedge clk) begin
        if (rst) begin
            scan_pos   <= 4'h0;
            scan_fresh <= 1'b1;
            alt_phase  <= 1'b0;
        end else if (period_end) begin
            // Each period scans from the lowest input
            scan_fresh <= 1'b1;
            alt_phase  <= 1'b0;
        end else if (event_end) begin
            // One scanned input per event, ascending
            scan_pos   <= next_in(scan_input_mask, scan_now);
            scan_fresh <= 1'b0;
            alt_phase  <= alternate_input_select & ~alt_phase;
        end
    end

    // Multiplexer and channel outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            sh0_pos_input      <= 4'h0;
            sh0_neg_input      <= 1'b0;
            sh_upper_pos_input <= 1'b0;
            sh_upper_neg_input <= 2'h0;
            sample_hold_sample <= 1'b0;
            channel_enable     <= 4'h0;
        end else begin
            sample_hold_sample <= (state == ST_SAMPLE) && !trigger;
            // One bit per enabled channel
            for (int c = 0; c < 4; c++) begin
                channel_enable[c] <= (4'(c) <= last_ch);
            end
            if (alt_phase) begin
                sh0_pos_input      <= sel[SEL_POS0B_LO +: 4];
                sh0_neg_input      <= sel[SEL_NEG0B];
                sh_upper_pos_input <= sel[SEL_POSUB];
                sh_upper_neg_input <= sel[SEL_NEGUB_LO +: 2];
            end else begin
                // Mask scan overrides the A positive field
                sh0_pos_input      <= scan_enable ? scan_now : sel[SEL_POS0A_LO +: 4];
                sh0_neg_input      <= sel[SEL_NEG0A];
                sh_upper_pos_input <= sel[SEL_POSUA];
                sh_upper_neg_input <= sel[SEL_NEGUA_LO +: 2];
            end
        end
    end

    // Store link
    assign buf_bus.wr_en   = result_in;
    assign buf_bus.wr_addr = wr_addr;
    assign buf_bus.wr_data = conv_result;
    assign buf_bus.rd_addr = reg_addr[3:0];

    asbc_result_store u_store (
        .clk (clk),
        .bus (buf_bus)
    );

    // Status word
    logic [15:0] status;
    assign status = {4'h0, wr_addr, event_cnt, 1'b0, state == ST_CONVERT,
                     state == ST_SAMPLE, buffer_half_status};

    // Read data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr >= REG_BUF_BASE) begin
                reg_rdata <= 16'(buf_bus.rd_data);
            end else begin
                case (reg_addr)
                    REG_CTRL:   reg_rdata <= ctrl;
                    REG_SELECT: reg_rdata <= sel;
                    REG_SCAN:   reg_rdata <= scan_input_mask;
                    REG_STATUS: reg_rdata <= status;
                    default:    reg_rdata <= 16'h0000;
                endcase
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule // asbc_top
`default_nettype wire

/* logic/asbc_pkg.sv */
// Shared constants for the converter sequencing and result-buffer block
package asbc_pkg;
    // Register indices on the plain register port
    localparam logic [4:0] REG_CTRL      = 5'h00;  // Mode and count control
    localparam logic [4:0] REG_SELECT    = 5'h01;  // Multiplexer A and B selections
    localparam logic [4:0] REG_SCAN      = 5'h02;  // Scan input mask
    localparam logic [4:0] REG_STATUS    = 5'h03;  // Read-only state
    localparam logic [4:0] REG_CMD       = 5'h04;  // Write-only command pulses
    localparam logic [4:0] REG_BUF_BASE  = 5'h10;  // Result buffer, 16 words
    // Control field positions
    localparam int CTRL_AUTO      = 0;   // Automatic sampling
    localparam int CTRL_SIMSAMP   = 1;   // Simultaneous sampling
    localparam int CTRL_SPLIT     = 2;   // Split buffer mode
    localparam int CTRL_ALT       = 3;   // Alternate A and B inputs
    localparam int CTRL_SCAN      = 4;   // Scan enable
    localparam int CTRL_CHCNT_LO  = 5;   // Channel count, 2 bits
    localparam int CTRL_SPI_LO    = 8;   // Samples per interrupt, 4 bits
    // Selection field positions
    localparam int SEL_POS0A_LO   = 0;   // Channel 0 positive, A
    localparam int SEL_NEG0A      = 4;   // Channel 0 negative, A
    localparam int SEL_POSUA      = 5;   // Channels 1-3 positive, A
    localparam int SEL_NEGUA_LO   = 6;   // Channels 1-3 negative, A
    localparam int SEL_POS0B_LO   = 8;   // Channel 0 positive, B
    localparam int SEL_NEG0B      = 12;  // Channel 0 negative, B
    localparam int SEL_POSUB      = 13;  // Channels 1-3 positive, B
    localparam int SEL_NEGUB_LO   = 14;  // Channels 1-3 negative, B
    // Command bits
    localparam int CMD_SAMPLE     = 0;   // Begin sampling
    localparam int CMD_TRIGGER    = 1;   // End sampling, start conversion
    // Reset values
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] SELECT_RESET = 16'h0000;
    localparam logic [15:0] SCAN_RESET   = 16'h0000;
    // Channel count encodings
    localparam logic [1:0] CHCNT_ONE = 2'h0;  // Channel 0 only
    localparam logic [1:0] CHCNT_TWO = 2'h1;  // Channels 0 and 1
    localparam logic [1:0] LAST_CH_ONE  = 2'h0;
    localparam logic [1:0] LAST_CH_TWO  = 2'h1;
    localparam logic [1:0] LAST_CH_FOUR = 2'h3;
    // Buffer geometry and input count
    localparam int BUF_WORDS  = 16;
    localparam int ADDR_W     = 4;
    localparam int NUM_INPUTS = 16;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } asbc_state_t;
endpackage

/* logic/asbc_buf_if.sv */
// Carrier between the sequencer and the result store
`timescale 1ns/1ps
`default_nettype none
interface asbc_buf_if #(
    parameter int RESULT_W = 10
);
    logic                wr_en;    // Store one result
    logic [3:0]          wr_addr;  // Word written
    logic [RESULT_W-1:0] wr_data;  // Result written
    logic [3:0]          rd_addr;  // Word read
    logic [RESULT_W-1:0] rd_data;  // Word read back
    modport seq   (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* logic/asbc_result_store.sv */
// Sixteen-word result store written only by the sequencer
`timescale 1ns/1ps
`default_nettype none
module asbc_result_store (
    input wire logic clk,
    asbc_buf_if.store bus
);
    import asbc_pkg::*;

    // Result words, no reset needed
    logic [$bits(bus.wr_data)-1:0] words [BUF_WORDS];

    // Sequencer writes only; software has no write path here
    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            words[bus.wr_addr] <= bus.wr_data;
        end
    end

    // Plain read, registered by the top
    assign bus.rd_data = words[bus.rd_addr];
endmodule // asbc_result_store
`default_nettype wire

/* bench/asbc_core_model.sv */
// Behavioural converter core answering conversion starts
`timescale 1ns/1ps
`default_nettype none
module asbc_core_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       slow,
    input  wire logic       conv_start,
    input  wire logic [1:0] conv_channel,
    input  wire logic [3:0] sh0_pos_input,
    output logic            conv_done,
    output logic [9:0]      conv_result
);
    logic       busy;  // Conversion in flight
    logic [3:0] cnt;   // Cycles left
    logic [9:0] val;   // Result to hand back
    // Result names the channel and, on channel 0, the input it saw; channels 1-3 give channel minus one
    always_ff @(posedge clk) begin
        conv_done <= 1'b0;
        if (rst) begin
            busy        <= 1'b0;
            cnt         <= 4'h0;
            conv_result <= 10'h3FF;
        end else if (conv_start) begin
            busy <= 1'b1;
            cnt  <= slow ? 4'h7 : 4'h1;
            val  <= {conv_channel, 4'h0, (conv_channel == 2'h0) ? sh0_pos_input : {2'h0, conv_channel - 2'h1}};
            conv_result <= ~conv_result;
        end else if (busy && cnt == 4'h0) begin
            busy        <= 1'b0;
            conv_done   <= 1'b1;
            conv_result <= val;
        end else begin
            cnt         <= cnt - {3'h0, busy};
            // Result lines toggle outside the done pulse
            conv_result <= ~conv_result;
        end
    end
endmodule // asbc_core_model
`default_nettype wire

/* bench/asbc_top_assertions.sv */
// Concurrent checks on the sequencing block ports
`timescale 1ns/1ps
`default_nettype none
module asbc_top_assertions
    import asbc_pkg::*;
#(
    parameter int RESULT_W = 10
) (
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [4:0]          reg_addr,
    input wire logic [15:0]         reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [15:0]         reg_rdata,
    input wire logic                conv_trigger,
    input wire logic                conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    input wire logic                conv_start,
    input wire logic [1:0]          conv_channel,
    input wire logic                sample_hold_sample,
    input wire logic [3:0]          channel_enable,
    input wire logic [3:0]          sh0_pos_input,
    input wire logic                sh0_neg_input,
    input wire logic                sh_upper_pos_input,
    input wire logic [1:0]          sh_upper_neg_input,
    input wire logic                conv_irq
);
    logic [15:0] ctrl_sh;  // Shadow of control
    logic [15:0] sel_sh;   // Shadow of selections
    logic [15:0] scan_sh;  // Shadow of scan mask
    logic [1:0]  last_ch;  // Last enabled channel
    assign last_ch = channel_enable[3] ? 2'h3 : {1'b0, channel_enable[1]};
    // Track software writes
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_sh <= 16'h0000;
            sel_sh  <= 16'h0000;
            scan_sh <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) ctrl_sh <= reg_wdata;
            if (reg_addr == REG_SELECT) sel_sh <= reg_wdata;
            if (reg_addr == REG_SCAN) scan_sh <= reg_wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_trigger_starts: assert property (sample_hold_sample && conv_trigger
        |=> conv_start && conv_channel == 2'h0 && !sample_hold_sample)
        else $error("trigger did not start channel 0");
    chk_next_channel: assert property (conv_done && conv_channel != last_ch
        |=> conv_start && conv_channel == $past(conv_channel) + 2'h1)
        else $error("channel order broken");
    chk_irq_cause: assert property (conv_irq |-> $past(conv_done) && conv_channel == last_ch)
        else $error("interrupt without final conversion");
    chk_start_pulse: assert property (conv_start |=> !conv_start [*2])
        else $error("start not a single pulse");
    chk_enable_count: assert property (conv_start |-> channel_enable ==
        (ctrl_sh[CTRL_CHCNT_LO+1] ? 4'hF : ctrl_sh[CTRL_CHCNT_LO] ? 4'h3 : 4'h1))
        else $error("enabled channels wrong");
    chk_neg_ref: assert property (conv_start && !ctrl_sh[CTRL_ALT] |-> sh0_neg_input == sel_sh[SEL_NEG0A])
        else $error("channel 0 negative select wrong");
    chk_upper_sel: assert property (conv_start && !ctrl_sh[CTRL_ALT] |->
        sh_upper_pos_input == sel_sh[SEL_POSUA] && sh_upper_neg_input == sel_sh[SEL_NEGUA_LO+1:SEL_NEGUA_LO])
        else $error("upper channel selects wrong");
    chk_pos_fixed: assert property (conv_start && !ctrl_sh[CTRL_ALT] && !ctrl_sh[CTRL_SCAN]
        |-> sh0_pos_input == sel_sh[3:0])
        else $error("channel 0 positive select wrong");
    chk_scan_masked: assert property (conv_start && ctrl_sh[CTRL_SCAN] && scan_sh != 16'h0000
        |-> scan_sh[sh0_pos_input])
        else $error("scanned input outside mask");
endmodule // asbc_top_assertions
bind asbc_top asbc_top_assertions #(.RESULT_W(RESULT_W)) u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_trigger(conv_trigger),
    .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start), .conv_channel(conv_channel),
    .sample_hold_sample(sample_hold_sample), .channel_enable(channel_enable), .sh0_pos_input(sh0_pos_input),
    .sh0_neg_input(sh0_neg_input), .sh_upper_pos_input(sh_upper_pos_input),
    .sh_upper_neg_input(sh_upper_neg_input), .conv_irq(conv_irq));
`default_nettype wire

/* bench/asbc_top_tb.sv */
// Self-checking bench for the sequencing block
`timescale 1ns/1ps
`default_nettype none
module asbc_top_tb;
    import asbc_pkg::*;
    logic        clk, rst, reg_wr, reg_rd, conv_trigger, conv_done, slow, conv_start;
    logic        sample_hold_sample, sh0_neg_input, sh_upper_pos_input, conv_irq;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rv;
    logic [9:0]  conv_result;
    logic [1:0]  conv_channel, sh_upper_neg_input;
    logic [3:0]  channel_enable, sh0_pos_input;
    int          err_count, checks, cycles, irqs;
    asbc_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_trigger(conv_trigger), .conv_done(conv_done),
        .conv_result(conv_result), .conv_start(conv_start), .conv_channel(conv_channel),
        .sample_hold_sample(sample_hold_sample), .channel_enable(channel_enable), .sh0_pos_input(sh0_pos_input),
        .sh0_neg_input(sh0_neg_input), .sh_upper_pos_input(sh_upper_pos_input),
        .sh_upper_neg_input(sh_upper_neg_input), .conv_irq(conv_irq));
    asbc_core_model core (.clk(clk), .rst(rst), .slow(slow), .conv_start(conv_start), .conv_channel(conv_channel),
        .sh0_pos_input(sh0_pos_input), .conv_done(conv_done), .conv_result(conv_result));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cycle limit and interrupt tally
    always @(posedge clk) begin
        cycles++;
        if (conv_irq === 1'b1) irqs++;
        if (cycles == 60000) begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out;
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [15:0] res(logic [1:0] c, logic [3:0] n);
        return {6'h00, c, 4'h0, n};
    endfunction
    task automatic wr(logic [4:0] a, logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic restart;
        @(posedge clk);
        rst <= 1'b1;
        repeat (15) @(posedge clk);
        rst  <= 1'b0;
        irqs = 0;
    endtask
    // Run sample events, then wait for the interrupt
    task automatic events(int n, bit cmd, bit swt = 1'b0);
        int k;
        irqs = 0;
        for (int i = 0; i < n; i++) begin
            if (cmd) wr(REG_CMD, 16'h0001);
            k = 0;
            while (sample_hold_sample !== 1'b1 && k < 200) begin
                @(posedge clk);
                k++;
            end
            if (i == n - 1) chk("early irq", 16'h0000, 16'(irqs));
            if (swt) begin
                // Software trigger through the command word
                wr(REG_CMD, 16'h0002);
            end else begin
                conv_trigger <= 1'b1;
                @(posedge clk);
                conv_trigger <= 1'b0;
            end
            repeat (2) @(posedge clk);
        end
        k = 0;
        while (irqs == 0 && k < 200) begin
            @(posedge clk);
            k++;
        end
        chk("irq count", 16'h0001, 16'(irqs));
    endtask
    task automatic t_regs;
        rd(REG_CTRL);
        chk("ctrl reset", CTRL_RESET, rv);
        wr(REG_SELECT, 16'h00A5);
        rd(REG_SELECT);
        chk("select", 16'h00A5, rv);
        rd(5'h05);
        chk("unmapped", 16'h0000, rv);
    endtask
    task automatic t_scan16;
        restart();
        wr(REG_SCAN, 16'hFFFF);
        wr(REG_SELECT, 16'h00D9);
        wr(REG_CTRL, 16'h0F11);
        events(16, 1'b0);
        for (int i = 0; i < 16; i++) begin
            rd(REG_BUF_BASE + 5'(i));
            chk("scan word", res(2'h0, 4'(i)), rv);
        end
        wr(REG_BUF_BASE, 16'h02AA);
        rd(REG_BUF_BASE);
        chk("buffer write", res(2'h0, 4'h0), rv);
    endtask
    task automatic t_scan_restart;
        restart();
        wr(REG_SCAN, 16'h0007);
        wr(REG_CTRL, 16'h0111);
        events(2, 1'b0);
        // New mask for the second period tells stale words apart
        wr(REG_SCAN, 16'h0006);
        events(2, 1'b0);
        rd(REG_BUF_BASE);
        chk("restart word 0", res(2'h0, 4'h1), rv);
        rd(REG_BUF_BASE + 5'h01);
        chk("restart word 1", res(2'h0, 4'h2), rv);
    endtask
    task automatic t_simscan;
        restart();
        wr(REG_SCAN, 16'h00F0);
        wr(REG_SELECT, 16'h0000);
        wr(REG_CTRL, 16'h0353);
        events(4, 1'b0);
        for (int i = 0; i < 16; i++) begin
            rd(REG_BUF_BASE + 5'(i));
            if (i % 4 == 0) chk("scanned", res(2'h0, 4'(4 + i / 4)), rv);
            else chk("fixed", res(2'(i % 4), 4'(i % 4 - 1)), rv);
        end
    endtask
    task automatic t_split;
        restart();
        slow <= 1'b1;
        wr(REG_SELECT, 16'h0003);
        wr(REG_CTRL, 16'h0046);
        rd(REG_STATUS);
        chk("half start", 16'h0000, {15'h0000, rv[0]});
        for (int p = 0; p < 2; p++) begin
            events(1, 1'b1);
            rd(REG_STATUS);
            chk("half toggle", 16'(1 - p), {15'h0000, rv[0]});
            for (int c = 0; c < 4; c++) begin
                rd(REG_BUF_BASE + 5'(8 * p + c));
                chk("split word", c == 0 ? res(2'h0, 4'h3) : res(2'(c), 4'(c - 1)), rv);
            end
        end
        slow <= 1'b0;
    endtask
    // Two channels, A and B selections alternating, software trigger
    task automatic t_alt;
        restart();
        wr(REG_SELECT, 16'h0F01);
        wr(REG_CTRL, 16'h032B);
        events(4, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rd(REG_BUF_BASE + 5'(i));
            if (i % 2 == 1) chk("alt upper", res(2'h1, 4'h0), rv);
            else chk("alt ch0", res(2'h0, (i % 4 == 2) ? 4'hF : 4'h1), rv);
        end
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        conv_trigger = 1'b0;
        slow = 1'b0;
        restart();
        t_regs();
        t_scan16();
        t_scan_restart();
        t_simscan();
        t_alt();
        t_split();
        close_out();
    end
endmodule // asbc_top_tb
`default_nettype wire
